/* verilog/lgp_pkg.sv */
// Constants, field layouts and state types for the LED grayscale PWM driver core.
// Assumes one 100 MHz core clock; every pin is asynchronous to it.
package lgp_pkg;

    // Channel and field geometry.
    localparam int NCH      = 24;
    localparam int NCOL     = 3;
    localparam int NGRP     = 8;
    localparam int GS_W     = 16;
    localparam int DC_W     = 7;
    localparam int GB_W     = 8;
    localparam int LVL_W    = 16;
    localparam int GD_SR_W  = 384;
    localparam int DG_SR_W  = 192;
    localparam int DC_LO    = 24;
    localparam int SPREAD_W = 5;

    // Counter values.
    localparam logic [GS_W-1:0] CNT_PRESET = 16'hFFFF;
    localparam logic [GS_W-1:0] CNT_ONE    = 16'h0001;

    // Open-LED qualification time.
    localparam int CLK_PERIOD_NS = 10;
    localparam int OPEN_ON_NS    = 200;
    localparam int OPEN_ON_CYC   = (OPEN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OPEN_CNT_W    = 5;
    localparam logic [OPEN_CNT_W-1:0] OPEN_SAT = OPEN_CNT_W'(OPEN_ON_CYC + 1);
    localparam logic [OPEN_CNT_W-1:0] OPEN_INC = 5'h01;

    // Status word layout loaded into the grayscale shift register.
    localparam int ST_SHDN_N  = 383;
    localparam int ST_WARN    = 382;
    localparam int ST_OVER    = 381;
    localparam int ST_OPEN_LO = 357;
    localparam int ST_DC_LO   = 189;

    // AXI4-Lite register map.
    localparam int AW = 8;
    localparam logic [AW-1:0] CTRL_OFF = 8'h00;
    localparam logic [AW-1:0] STAT_OFF = 8'h04;
    localparam logic [AW-1:0] OPEN_OFF = 8'h08;
    localparam int CTRL_BLANK = 0;
    localparam int STAT_SHDN  = 0;
    localparam int STAT_WARN  = 1;
    localparam int STAT_OVER  = 2;
    localparam int STAT_ALARM = 3;
    localparam int STAT_CNT   = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Pins that arrive from outside the core clock domain.
    typedef struct packed {
        logic            shift_clock;
        logic            serial_in;
        logic            latch_strobe;
        logic            grayscale_clock;
        logic            load_mode_select;
        logic            edge_polarity_select;
        logic            single_cycle_select;
        logic            spread_waveform_select;
        logic            blank;
        logic            warn_temp_flag;
        logic            overtemp_flag;
        logic [NCH-1:0]  led_low_volt;
    } lgp_pins_t;
    localparam int PIN_W = $bits(lgp_pins_t);

    // State of the core apart from the pin synchroniser flops.
    typedef struct packed {
        logic [GD_SR_W-1:0]              gd_sr;
        logic [DG_SR_W-1:0]              dg_sr;
        logic [GD_SR_W-1:0]              gs_lat;
        logic [DG_SR_W-1:0]              dg_lat;
        logic [GS_W-1:0]                 cnt;
        logic [NGRP-2:0][GS_W-1:0]       hist;
        logic [NGRP-2:0]                 en_hist;
        logic                            started;
        logic                            oneshot_done;
        logic                            lat_prev;
        logic                            stat_pend;
        logic                            shutdown;
        logic [NCH-1:0]                  open;
        logic [NCH-1:0][OPEN_CNT_W-1:0]  on_cnt;
        logic [NCH-1:0]                  leds;
        logic [NCH-1:0][LVL_W-1:0]       level;
        logic                            alarm_n;
        logic                            sout;
        logic                            soft_blank;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            rvalid;
        logic [1:0]                      rresp;
        logic [31:0]                     rdata;
    } lgp_state_t;

endpackage

/* verilog/lgp_pin_sync.sv */
// Two-flop synchroniser bank with edge detection for asynchronous pins.
// Assumes the inputs may change at any time relative to the core clock.
`timescale 1ns/1ps

module lgp_pin_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] prev;

    ////////////////////////////////////////////////////////////////////////////
    // The first flop feeds only the second; edges look at later stages.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            meta   <= '0;
            stable <= '0;
            prev   <= '0;
        end else begin
            meta   <= async_i;
            stable <= meta;
            prev   <= stable;
        end
    end

    // Edges are one-cycle pulses aligned with the synchronised level.
    assign sync_o = stable;
    assign rise_o = stable & ~prev;
    assign fall_o = ~stable & prev;

endmodule // lgp_pin_sync

/* verilog/lgp_core.sv */
// Digital core of a 24-channel LED grayscale PWM driver with AXI4-Lite status.
// Assumes all pins are asynchronous and far slower than the 100 MHz core clock.
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps

module lgp_core
    import lgp_pkg::*;
(
    input  wire logic                      core_clk_i,
    input  wire logic                      reset_i,
    input  wire logic                      shift_clock_i,
    input  wire logic                      serial_in_i,
    input  wire logic                      latch_strobe_i,
    input  wire logic                      grayscale_clock_i,
    input  wire logic                      load_mode_select_i,
    input  wire logic                      edge_polarity_select_i,
    input  wire logic                      single_cycle_select_i,
    input  wire logic                      spread_waveform_select_i,
    input  wire logic                      blank_i,
    input  wire logic                      warn_temp_flag_i,
    input  wire logic                      overtemp_flag_i,
    input  wire logic [NCH-1:0]            led_low_volt_i,
    output logic      [NCH-1:0]            led_output_o,
    output logic      [NCH-1:0][LVL_W-1:0] led_current_level_o,
    output logic                           alarm_n_o,
    output logic                           serial_out_o,
    input  wire logic [AW-1:0]             s_axi_awaddr,
    input  wire logic                      s_axi_awvalid,
    output logic                           s_axi_awready,
    input  wire logic [31:0]               s_axi_wdata,
    input  wire logic [3:0]                s_axi_wstrb,
    input  wire logic                      s_axi_wvalid,
    output logic                           s_axi_wready,
    output logic [1:0]                     s_axi_bresp,
    output logic                           s_axi_bvalid,
    input  wire logic                      s_axi_bready,
    input  wire logic [AW-1:0]             s_axi_araddr,
    input  wire logic                      s_axi_arvalid,
    output logic                           s_axi_arready,
    output logic [31:0]                    s_axi_rdata,
    output logic [1:0]                     s_axi_rresp,
    output logic                           s_axi_rvalid,
    input  wire logic                      s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Grayscale word of one channel.
    function automatic logic [GS_W-1:0] gs_of(input logic [GD_SR_W-1:0] v, input int c);
        return v[c*GS_W +: GS_W];
    endfunction

    // Correction value of one channel; it sits above the brightness bytes.
    function automatic logic [DC_W-1:0] dc_of(input logic [DG_SR_W-1:0] v, input int c);
        return v[DC_LO + c*DC_W +: DC_W];
    endfunction

    // Brightness byte of one colour.
    function automatic logic [GB_W-1:0] gb_of(input logic [DG_SR_W-1:0] v, input int k);
        return v[k*GB_W +: GB_W];
    endfunction

    // Rotating the low counter bits to the top chops the pulse into sections.
    function automatic logic [GS_W-1:0] cmp_of(input logic [GS_W-1:0] c, input logic spr);
        return spr ? c : {c[SPREAD_W-1:0], c[GS_W-1:SPREAD_W]};
    endfunction

    // Word-aligned address match.
    function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
        return a[AW-1:2] == off[AW-1:2];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation.

    lgp_pins_t  pin_raw;
    lgp_pins_t  ps;
    lgp_pins_t  pr;
    lgp_pins_t  pf;

    assign pin_raw = {shift_clock_i, serial_in_i, latch_strobe_i, grayscale_clock_i,
                      load_mode_select_i, edge_polarity_select_i, single_cycle_select_i,
                      spread_waveform_select_i, blank_i, warn_temp_flag_i,
                      overtemp_flag_i, led_low_volt_i};

    lgp_pin_sync #(.W(PIN_W)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .async_i    (pin_raw),
        .sync_o     (ps),
        .rise_o     (pr),
        .fall_o     (pf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State and combinational helpers.

    lgp_state_t      s;
    lgp_state_t      next_s;
    logic            lat_act;
    logic            lat_rel;
    logic            sck_edge;
    logic            gck_step;
    logic            gck_any;
    logic            blank;
    logic            en_now;
    logic            aw_go;
    logic            ar_go;
    logic [GS_W-1:0] grp_cnt;
    logic            grp_en;
    logic [31:0]     rd;

    // The strobe's active level flips with the edge select pin.
    assign lat_act  = ps.latch_strobe ^ ps.edge_polarity_select;
    assign lat_rel  = s.lat_prev & ~lat_act;
    assign sck_edge = ps.edge_polarity_select ? pf.shift_clock : pr.shift_clock;
    assign gck_step = ps.edge_polarity_select ? pf.grayscale_clock
                                              : pr.grayscale_clock;
    assign gck_any  = pr.grayscale_clock | pf.grayscale_clock;
    assign blank    = ps.blank | s.soft_blank;
    assign en_now   = ~blank & ~(ps.single_cycle_select & s.oneshot_done);

    // Handshake outputs are combinational; one transaction each way at a time.
    assign aw_go         = s_axi_awvalid & s_axi_wvalid & ~s.bvalid;
    assign ar_go         = s_axi_arvalid & ~s.rvalid;
    assign s_axi_awready = aw_go;
    assign s_axi_wready  = aw_go;
    assign s_axi_arready = ar_go;

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        next_s  = s;
        grp_cnt = s.cnt;
        grp_en  = en_now;
        rd      = '0;
        next_s.lat_prev = lat_act;

        // Shift path: each mode owns its register, fed at the LSB end.
        if (sck_edge) begin
            next_s.stat_pend = 1'b0;
            if (ps.load_mode_select) begin
                next_s.dg_sr = {s.dg_sr[DG_SR_W-2:0], ps.serial_in};
            end else begin
                next_s.gd_sr = {s.gd_sr[GD_SR_W-2:0], ps.serial_in};
            end
        end

        // Transparent latches and counter preset while the strobe is active.
        if (lat_act) begin
            next_s.dg_lat       = s.dg_sr;
            next_s.cnt          = CNT_PRESET;
            next_s.started      = 1'b0;
            next_s.oneshot_done = 1'b0;
            next_s.stat_pend    = 1'b0;
            if (!ps.load_mode_select) begin
                next_s.gs_lat = s.gd_sr;
            end
        end else if (gck_step) begin
            // The first step rolls the preset to zero; a later wrap ends a cycle.
            next_s.cnt     = s.cnt + CNT_ONE;
            next_s.started = 1'b1;
            if (s.started && s.cnt == CNT_PRESET) begin
                next_s.oneshot_done = 1'b1;
            end
        end

        // Status replaces the grayscale data once the latch is released in grayscale load mode.
        if (lat_rel && !ps.load_mode_select) begin
            next_s.gd_sr                     = '0;
            next_s.gd_sr[ST_SHDN_N]          = ~s.shutdown;
            next_s.gd_sr[ST_WARN]            = ps.warn_temp_flag;
            next_s.gd_sr[ST_OVER]            = ps.overtemp_flag;
            next_s.gd_sr[ST_OPEN_LO +: NCH]  = s.open;
            next_s.gd_sr[ST_DC_LO +: NCH*DC_W] = s.dg_lat[DG_SR_W-1:DC_LO];
            next_s.stat_pend                 = 1'b1;
        end else if (s.stat_pend && gck_step) begin
            // Open flags settle over a few grayscale steps, so keep them fresh.
            next_s.gd_sr[ST_OPEN_LO +: NCH] = s.open;
        end

        // Each half grayscale period hands counter and enable one group down.
        if (gck_any) begin
            next_s.hist    = {s.hist[NGRP-3:0], s.cnt};
            next_s.en_hist = {s.en_hist[NGRP-3:0], en_now};
        end

        // Shutdown holds until the die falls below the warning threshold.
        if (ps.overtemp_flag) begin
            next_s.shutdown = 1'b1;
        end else if (!ps.warn_temp_flag) begin
            next_s.shutdown = 1'b0;
        end

        // Per-channel compare, open detection and current level.
        for (int c = 0; c < NCH; c++) begin
            if (c / NCOL != 0) begin
                grp_cnt = s.hist[c/NCOL - 1];
                grp_en  = s.en_hist[c/NCOL - 1];
            end else begin
                grp_cnt = s.cnt;
                grp_en  = en_now;
            end
            next_s.leds[c] = grp_en & ~s.shutdown
                           & (gs_of(s.gs_lat, c) > cmp_of(grp_cnt, ps.spread_waveform_select));
            if (s.leds[c] && !blank) begin
                if (s.on_cnt[c] != OPEN_SAT) begin
                    next_s.on_cnt[c] = s.on_cnt[c] + OPEN_INC;
                end
            end else begin
                next_s.on_cnt[c] = '0;
            end
            next_s.open[c]  = (s.on_cnt[c] == OPEN_SAT) & ps.led_low_volt[c]
                            & s.leds[c] & ~blank;
            // Both factors widen to the level width first so the product keeps its top bit.
            next_s.level[c] = (LVL_W'(dc_of(s.dg_lat, c)) + 16'h0001)
                            * (LVL_W'(gb_of(s.dg_lat, c % NCOL)) + 16'h0001);
        end

        // Alarm pin: shutdown always, warning and open only when unblanked.
        next_s.alarm_n = ~(s.shutdown | ps.overtemp_flag
                         | (~blank & (ps.warn_temp_flag | (|s.open))));

        // Serial out follows the MSB of the register of the selected mode.
        next_s.sout = ps.load_mode_select ? next_s.dg_sr[DG_SR_W-1]
                                          : next_s.gd_sr[GD_SR_W-1];

        // Register writes.
        if (aw_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp  = RESP_SLVERR;
            if (hit(s_axi_awaddr, CTRL_OFF)) begin
                next_s.bresp = RESP_OKAY;
                if (s_axi_wstrb[0]) begin
                    next_s.soft_blank = s_axi_wdata[CTRL_BLANK];
                end
            end else if (hit(s_axi_awaddr, STAT_OFF) || hit(s_axi_awaddr, OPEN_OFF)) begin
                next_s.bresp = RESP_OKAY;
            end
        end else if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        // Register reads.
        if (ar_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp  = RESP_OKAY;
            if (hit(s_axi_araddr, CTRL_OFF)) begin
                rd[CTRL_BLANK] = s.soft_blank;
            end else if (hit(s_axi_araddr, STAT_OFF)) begin
                rd[STAT_SHDN]             = s.shutdown;
                rd[STAT_WARN]             = ps.warn_temp_flag;
                rd[STAT_OVER]             = ps.overtemp_flag;
                rd[STAT_ALARM]            = ~s.alarm_n;
                rd[STAT_CNT +: GS_W]      = s.cnt;
            end else if (hit(s_axi_araddr, OPEN_OFF)) begin
                rd[NCH-1:0] = s.open;
            end else begin
                next_s.rresp = RESP_SLVERR;
            end
            next_s.rdata = rd;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register. Reset stands in for the missing power-on clear.
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            s         <= '0;
            s.cnt     <= CNT_PRESET;
            s.alarm_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs other than the ready signals, all straight from the state register.
    assign led_output_o        = s.leds;
    assign led_current_level_o = s.level;
    assign alarm_n_o           = s.alarm_n;
    assign serial_out_o        = s.sout;
    assign s_axi_bvalid        = s.bvalid;
    assign s_axi_bresp         = s.bresp;
    assign s_axi_rvalid        = s.rvalid;
    assign s_axi_rresp         = s.rresp;
    assign s_axi_rdata         = s.rdata;

endmodule // lgp_core

/* dv/lgp_core_sva.sv */
// Port-level checks for the LED grayscale PWM core.
// Assumes it is bound onto lgp_core; all pins are asynchronous to core_clk_i.
`timescale 1ns/1ps

module lgp_core_sva
    import lgp_pkg::*;
(
    input wire logic           core_clk_i,
    input wire logic           reset_i,
    input wire logic           blank_i,
    input wire logic           warn_temp_flag_i,
    input wire logic           overtemp_flag_i,
    input wire logic [NCH-1:0] led_low_volt_i,
    input wire logic [NCH-1:0] led_output_o,
    input wire logic           alarm_n_o,
    input wire logic           s_axi_awvalid,
    input wire logic           s_axi_awready,
    input wire logic           s_axi_bvalid,
    input wire logic           s_axi_bready,
    input wire logic           s_axi_arvalid,
    input wire logic           s_axi_arready,
    input wire logic           s_axi_rvalid,
    input wire logic           s_axi_rready
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    // Cycles blanked, saturating.
    logic [7:0] blank_cyc;
    always_ff @(posedge core_clk_i) begin
        if (reset_i || !blank_i) begin
            blank_cyc <= 8'h00;
        end else if (blank_cyc != 8'hFF) begin
            blank_cyc <= blank_cyc + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answers come one cycle after the take and stand until accepted.
    chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
        else $error("write not answered");
    chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read data dropped");
    // Thermal and blanking effects, allowing for the pin synchroniser.
    chk_warn_alarm: assert property ((warn_temp_flag_i && !blank_i) [*7] |-> !alarm_n_o)
        else $error("alarm not raised on warning");
    chk_over_dark: assert property (
        overtemp_flag_i [*8] |-> led_output_o == '0 && !alarm_n_o)
        else $error("outputs lit in shutdown");
    chk_cool_clear: assert property (
        (!warn_temp_flag_i && !overtemp_flag_i && led_low_volt_i == '0) [*8] |-> alarm_n_o)
        else $error("alarm held after cooling");
    chk_blank_dark: assert property (blank_cyc > 8'h3C |-> led_output_o == '0)
        else $error("outputs lit while blanked");
endmodule // lgp_core_sva

bind lgp_core lgp_core_sva u_lgp_core_sva (.*);

/* dv/lgp_host_model.sv */
// Behavioural host driving the serial link, latch, grayscale clock and polarity pins.
// Assumes the core clock; every pin changes just after its rising edge.
`timescale 1ns/1ps

module lgp_host_model (
    input  wire logic core_clk_i,
    input  wire logic serial_out_i,
    output logic      edge_sel_o,
    output logic      shift_clock_o,
    output logic      serial_in_o,
    output logic      latch_strobe_o,
    output logic      grayscale_clock_o
);
    int half = 4;  // Half period in core cycles; 4 gives the 80 ns grayscale clock and a 90 ns link clock.

    // Idle levels follow polarity: each first toggle is active.
    task automatic set_pol(input logic p);
        @(posedge core_clk_i);
        edge_sel_o        <= p;
        shift_clock_o     <= p;
        latch_strobe_o    <= p;
        grayscale_clock_o <= p;
    endtask
    initial set_pol(1'h0);

    // One frame; the bit leaving the core is caught before each active edge.
    task automatic xfer(input logic [383:0] d, input int n, output logic [383:0] q);
        q = '0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk_i);
            serial_in_o <= d[i];
            repeat (half) @(posedge core_clk_i);
            q[i] = serial_out_i;
            shift_clock_o <= !edge_sel_o;
            repeat (half) @(posedge core_clk_i);
            shift_clock_o <= edge_sel_o;
            serial_in_o   <= !d[i];  // Line no longer shows the bit.
        end
    endtask

    // Strobe held long enough for the synchroniser.
    task automatic latch_pulse();
        @(posedge core_clk_i);
        latch_strobe_o <= !edge_sel_o;
        repeat (2 * half) @(posedge core_clk_i);
        latch_strobe_o <= edge_sel_o;
    endtask

    // Runs n active edges, then stands still.
    task automatic gray_steps(input int n);
        repeat (2 * n) begin
            repeat (half) @(posedge core_clk_i);
            grayscale_clock_o <= !grayscale_clock_o;
        end
    endtask
endmodule // lgp_host_model

/* dv/lgp_core_bench.sv */
// Self-checking bench for the LED PWM core.
// Assumes lgp_core, the bound checker and lgp_host_model are compiled before it.
`timescale 1ns/1ps

module lgp_core_bench;
    import lgp_pkg::*;

    logic core_clk_i = 1'h0, reset_i = 1'h1, load_mode_select_i = 1'h1, blank_i = 1'h0;
    logic single_cycle_select_i = 1'h0, spread_waveform_select_i = 1'h1;
    logic warn_temp_flag_i = 1'h0, overtemp_flag_i = 1'h0, alarm_n_o, serial_out_o;
    logic shift_clock_i, serial_in_i, latch_strobe_i, grayscale_clock_i, edge_polarity_select_i;
    logic [NCH-1:0] led_low_volt_i = '0, led_output_o, exp_led;
    logic [NCH-1:0][LVL_W-1:0] led_current_level_o;
    logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [383:0] gd = '0, dg = '0, q;
    int fail_count = 0, check_count = 0;

    // 100 MHz core clock.
    always #5 core_clk_i = !core_clk_i;

    lgp_core u_lgp_core (.*);
    lgp_host_model u_host (
        .core_clk_i       (core_clk_i),
        .serial_out_i     (serial_out_o),
        .edge_sel_o       (edge_polarity_select_i),
        .shift_clock_o    (shift_clock_i),
        .serial_in_o      (serial_in_i),
        .latch_strobe_o   (latch_strobe_i),
        .grayscale_clock_o(grayscale_clock_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Counted comparison.
    task automatic check(input string what, input logic [383:0] seen, input logic [383:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Sole verdict.
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Bounded wait; the edge after a settled high is the handshake edge.
    task automatic await(ref logic s);
        int i;
        i = 0;
        #1;
        while (s !== 1'h1 && i < 200) begin
            @(posedge core_clk_i);
            #1;
            i++;
        end
        if (s !== 1'h1) begin
            fail_count++;
            finish_test();
        end
        @(posedge core_clk_i);
    endtask

    // Write; address and data together.
    task automatic axi_wr(input logic [AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        await(s_axi_awready);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid  <= 1'h0;
        await(s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask

    // Read; rready stays up until rvalid is seen.
    task automatic axi_rd(input logic [AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk_i);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        await(s_axi_arready);
        s_axi_arvalid <= 1'h0;
        await(s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus map, loads, PWM, status, thermal, blanking.
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'h0;
        axi_rd(STAT_OFF, rd, rs);
        check("counter", rd[31:16], CNT_PRESET);
        axi_wr(CTRL_OFF, 32'h00000001, rs);
        axi_rd(CTRL_OFF, rd, rs);
        check("ctrl", rd[0], 1'h1);
        axi_wr(8'h0C, 32'h00000001, rs);
        check("bresp", rs, RESP_SLVERR);
        axi_rd(8'h0C, rd, rs);
        check("rresp", rs, RESP_SLVERR);
        axi_wr(CTRL_OFF, 32'h00000000, rs);
        check("bresp", rs, RESP_OKAY);
        // Small grayscale words keep the unused upper bits zero.
        for (int c = 0; c < NCH; c++) begin
            gd[16*c +: 16] = 16'(c);
            dg[24+7*c +: 7] = 7'(c);
        end
        dg[23:0] = 24'h7F01FF;
        @(posedge core_clk_i);
        load_mode_select_i <= 1'h0;
        u_host.xfer(gd, GD_SR_W, q);
        @(posedge core_clk_i);
        load_mode_select_i <= 1'h1;
        u_host.xfer(dg, DG_SR_W, q);
        u_host.latch_pulse();
        repeat (8) @(posedge core_clk_i);
        for (int c = 0; c < NCH; c++) begin
            check("level", led_current_level_o[c], (c + 1) * (dg[8*(c%3) +: 8] + 1));
        end
        u_host.gray_steps(20);
        repeat (8) @(posedge core_clk_i);
        check("leds", led_output_o, '0);
        // Falling-edge link; channel 23 lit with a low pin, channel 0 dark with one.
        @(posedge core_clk_i);
        load_mode_select_i <= 1'h0;
        led_low_volt_i     <= 24'h800001;
        u_host.set_pol(1'h1);
        u_host.latch_pulse();
        u_host.gray_steps(20);
        repeat (8) @(posedge core_clk_i);
        for (int c = 0; c < NCH; c++) begin
            exp_led[c] = c > (41 - c / 3) / 2 - 1;
        end
        check("leds", led_output_o, exp_led);
        axi_rd(STAT_OFF, rd, rs);
        check("counter", rd[31:16], 16'h0013);
        axi_rd(OPEN_OFF, rd, rs);
        check("open", rd[23:0], 24'h800000);
        check("alarm", alarm_n_o, 1'h0);
        u_host.xfer('0, GD_SR_W, q);
        check("status", q[383:189], {3'h4, 24'h800000, dg[191:24]});
        led_low_volt_i <= '0;
        repeat (10) @(posedge core_clk_i);
        check("alarm", alarm_n_o, 1'h1);
        // Warning, shutdown, then cooling in two stages.
        warn_temp_flag_i <= 1'h1;
        repeat (10) @(posedge core_clk_i);
        check("alarm", alarm_n_o, 1'h0);
        overtemp_flag_i <= 1'h1;
        repeat (10) @(posedge core_clk_i);
        check("leds", led_output_o, '0);
        axi_rd(STAT_OFF, rd, rs);
        check("thermal", rd[2:0], 3'h7);
        overtemp_flag_i <= 1'h0;
        repeat (10) @(posedge core_clk_i);
        check("leds", led_output_o, '0);
        warn_temp_flag_i <= 1'h0;
        repeat (10) @(posedge core_clk_i);
        check("alarm", alarm_n_o, 1'h1);
        check("leds", led_output_o, exp_led);
        blank_i <= 1'h1;
        u_host.gray_steps(10);
        check("leds", led_output_o, '0);
        blank_i <= 1'h0;
        finish_test();
    end
endmodule // lgp_core_bench
